// *** bmseq_top.sv ***
// Function
// RULE1 - Byte form copies while low count nonzero
// RULE2 - Stop at zero; zero start skips transfer
// RULE3 - Word form tests full word count
// RULE4 - Takes eight plus four states per byte
// RULE5 - Timing holds for zero-wait memory only
// RULE6 - Word form steps by one; flags untouched
module bmseq_top
  import bmseq_pkg::*;
#(
  parameter int FIFO_D = FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire bmseq_cmd_t i_cmd,
  output logic o_busy,
  output logic o_done,
  output bmseq_res_t o_res,
  output logic o_rd_req,
  output logic [ADDR_W-1:0] o_rd_addr,
  input wire logic i_rd_ack,
  input wire logic [DATA_W-1:0] i_rd_data,
  output logic o_wr_req,
  output logic [ADDR_W-1:0] o_wr_addr,
  output logic [DATA_W-1:0] o_wr_data,
  input wire logic i_wr_ack
);
  // Depths below two leave no room for a read in flight
  if (FIFO_D < 2) begin : bad_depth_g
    $error("fifo depth too small");
  end

  // ****************************************
  // State
  // ****************************************
  bmseq_state_t st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] rd_left_r;
  logic [CNT_W-1:0] slot_r;
  logic [ADDR_W-1:0] src_r, dst_r;
  logic [3:0] cyc_r;
  logic busy_r, done_r, rd_req_r, wr_req_r;
  logic [DATA_W-1:0] wr_data_r;
  bmseq_res_t res_r;
  logic f_ready, f_valid;
  logic [DATA_W-1:0] f_data;

  // ****************************************
  // Decode
  // ****************************************
  // Zero test on low byte or full word
  wire start_zero = i_cmd.word_form ? (i_cmd.count == WORD_ZERO) //RULE3
                  : (i_cmd.count[DATA_W-1:0] == LOW_ZERO); //RULE2
  // Byte form drops the high byte of the count
  wire [CNT_W-1:0] cnt_load = start_zero ? WORD_ZERO
                            : i_cmd.word_form ? i_cmd.count //RULE3
                            : {LOW_ZERO, i_cmd.count[DATA_W-1:0]}; //RULE1
  wire take_start = st_r == BMS_IDLE && i_start;
  wire moving = st_r == BMS_SETUP || st_r == BMS_MOVE;
  wire cyc_end = cyc_r == CYC_ONE;
  wire setup_end = st_r == BMS_SETUP && cyc_end;
  wire slot_end = st_r == BMS_MOVE && cyc_end;
  wire last_slot = slot_r == CNT_ONE;
  // Slow memory simply stretches the read and write phases
  wire rd_done = rd_req_r && i_rd_ack; //RULE5
  wire wr_done = wr_req_r && i_wr_ack; //RULE5
  // One read in flight at most, so room now is still room at its ack
  wire rd_issue = moving && !rd_req_r && rd_left_r != WORD_ZERO
                && f_ready; //RULE1
  wire wr_take = moving && !wr_req_r && f_valid; //RULE1
  // Finished only when the time budget and the copy are both spent
  wire time_up = slot_r == WORD_ZERO || (slot_end && last_slot); //RULE4
  wire copied = cnt_r == WORD_ZERO || (wr_done && cnt_r == CNT_ONE); //RULE2

  // Read data is staged in the fifo; the write side drains it
  bmseq_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_D)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(rd_done),
    .o_in_ready(f_ready),
    .i_in_data(i_rd_data),
    .o_out_valid(f_valid),
    .i_out_ready(wr_take),
    .o_out_data(f_data)
  );

  // ****************************************
  // Sequencing
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      BMS_IDLE: if (i_start) st_nxt = BMS_SETUP;
      // Fixed overhead of eight states, also spent for a zero count
      BMS_SETUP: if (cyc_end) st_nxt = (slot_r == WORD_ZERO) ? BMS_DONE
                                   : BMS_MOVE; //RULE2 RULE4
      // Slow memory may keep the copy going past its last slot
      BMS_MOVE: if (time_up && copied) st_nxt = BMS_DONE; //RULE4 RULE5
      BMS_DONE: st_nxt = BMS_IDLE;
      default: st_nxt = BMS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_r <= BMS_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Overhead budget from the start edge, then four states per byte
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cyc_r <= CYC_ZERO;
    end else if (take_start) begin
      cyc_r <= BASE_CYC - CYC_ONE; //RULE4
    end else if (setup_end || (slot_end && !last_slot)) begin
      cyc_r <= BYTE_CYC; //RULE4
    end else if (cyc_r != CYC_ZERO) begin
      cyc_r <= cyc_r - CYC_ONE;
    end
  end

  // Slots left to spend; the copy itself may run ahead of them
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      slot_r <= WORD_ZERO;
    end else if (take_start) begin
      slot_r <= cnt_load; //RULE4
    end else if (slot_end) begin
      slot_r <= slot_r - CNT_ONE; //RULE4
    end
  end

  // Pointers and counts; reads may lead writes by a few bytes
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_r <= WORD_ZERO;
      rd_left_r <= WORD_ZERO;
      src_r <= '0;
      dst_r <= '0;
    end else if (take_start) begin
      cnt_r <= cnt_load; //RULE3
      rd_left_r <= cnt_load; //RULE3
      src_r <= i_cmd.src;
      dst_r <= i_cmd.dst;
    end else begin
      if (rd_done) begin
        src_r <= src_r + PTR_ONE; //RULE1 RULE6
        rd_left_r <= rd_left_r - CNT_ONE; //RULE1
      end
      if (wr_done) begin
        dst_r <= dst_r + PTR_ONE; //RULE1 RULE6
        cnt_r <= cnt_r - CNT_ONE; //RULE1 RULE6
      end
    end
  end

  // Bus requests held until acknowledged
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rd_req_r <= 1'b0;
      wr_req_r <= 1'b0;
      wr_data_r <= '0;
    end else begin
      if (rd_done) rd_req_r <= 1'b0;
      else if (rd_issue) rd_req_r <= 1'b1; //RULE1
      if (wr_done) wr_req_r <= 1'b0;
      else if (wr_take) begin
        wr_req_r <= 1'b1; //RULE1
        wr_data_r <= f_data;
      end
    end
  end

  // Status and results; no flag output is touched at all
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      res_r <= '0;
    end else begin
      busy_r <= st_nxt != BMS_IDLE;
      done_r <= st_r == BMS_DONE; //RULE6
      if (st_r == BMS_DONE) begin
        res_r.count <= cnt_r;
        res_r.src <= src_r;
        res_r.dst <= dst_r;
      end
    end
  end

  assign o_busy = busy_r;
  assign o_done = done_r;
  assign o_res = res_r;
  assign o_rd_req = rd_req_r;
  assign o_rd_addr = src_r;
  assign o_wr_req = wr_req_r;
  assign o_wr_addr = dst_r;
  assign o_wr_data = wr_data_r;

  // ****************************************
  // Checks
  // ****************************************
  int unsigned run_len;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || st_r == BMS_IDLE) run_len <= 0;
    else run_len <= run_len + 1;
  end

  zero_skip_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) //RULE2
    st_r == BMS_IDLE && i_start && start_zero
    |=> !rd_req_r [*8])
    else $error("zero count started a read");
  setup_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) //RULE4
    st_r == BMS_SETUP && $past(st_r) == BMS_IDLE |-> ##7 st_r != BMS_SETUP)
    else $error("setup overhead wrong length");
  done_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) //RULE2
    o_done |=> !o_done)
    else $error("done longer than one cycle");
  // The start edge itself is the first overhead state
  min_time_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) //RULE4
    st_r == BMS_DONE |-> run_len >= BASE_STATES - 1)
    else $error("instruction finished too fast");
  src_step_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) //RULE1
    rd_done |=> src_r == $past(src_r) + PTR_ONE)
    else $error("source pointer not stepped");
  cnt_step_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) //RULE6
    wr_done |=> cnt_r == $past(cnt_r) - CNT_ONE)
    else $error("count not decremented");
  no_wr_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) //RULE2
    st_r == BMS_SETUP && cnt_r == WORD_ZERO |-> !wr_req_r)
    else $error("write issued with zero count");
  word_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) //RULE3
    st_r == BMS_IDLE && i_start && i_cmd.word_form
    |=> cnt_r == $past(i_cmd.count))
    else $error("word count not loaded whole");
  stop_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) //RULE2
    st_r == BMS_DONE |-> cnt_r == WORD_ZERO)
    else $error("finished with count left");
  fifo_room_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) //RULE1
    rd_done |-> f_ready)
    else $error("read data arrived with the fifo full");
  slot_spent_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) //RULE4
    st_r == BMS_DONE |-> slot_r == WORD_ZERO)
    else $error("finished before its time budget");
  zero_cv: cover property (@(posedge i_clk) st_r == BMS_SETUP
    && cnt_r == WORD_ZERO ##[1:8] o_done);
  byte_cv: cover property (@(posedge i_clk) wr_done && cnt_r == CNT_ONE);
  late_cv: cover property (@(posedge i_clk) st_r == BMS_MOVE
    && slot_r == WORD_ZERO && cnt_r != WORD_ZERO);
  word_cv: cover property (@(posedge i_clk) st_r == BMS_IDLE && i_start
    && i_cmd.word_form && i_cmd.count[7:0] == LOW_ZERO && !start_zero);
endmodule

// *** bmseq_pkg.sv ***
package bmseq_pkg;
  // ****************************************
  // Widths and timing
  // ****************************************
  localparam int ADDR_W = 24;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  localparam int FIFO_DEPTH = 8;
  // Fixed overhead and per-byte cost in states
  localparam int BASE_STATES = 8;
  localparam int BYTE_STATES = 4;
  localparam logic [3:0] BASE_CYC = 4'(BASE_STATES);
  localparam logic [3:0] BYTE_CYC = 4'(BYTE_STATES);
  localparam logic [3:0] CYC_ZERO = 4'h0;
  localparam logic [3:0] CYC_ONE = 4'h1;
  localparam logic [7:0] LOW_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [23:0] PTR_ONE = 24'h00_0001;

  // Command carrier from the instruction decoder
  typedef struct packed {
    logic word_form;
    logic [CNT_W-1:0] count;
    logic [ADDR_W-1:0] src;
    logic [ADDR_W-1:0] dst;
  } bmseq_cmd_t;

  // Register results handed back at the end
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [ADDR_W-1:0] src;
    logic [ADDR_W-1:0] dst;
  } bmseq_res_t;

  // Reads and writes overlap while moving, paced by the fifo and the acks
  typedef enum logic [1:0] {
    BMS_IDLE, BMS_SETUP, BMS_MOVE, BMS_DONE
  } bmseq_state_t;
endpackage

// *** bmseq_fifo.sv ***
module bmseq_fifo
  import bmseq_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] LVL_ZERO = '0;
  localparam logic [AW:0] LVL_FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] PTR_ONE_L = AW'(1);

  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : bad_depth_g
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] lvl_r;
  logic [WIDTH-1:0] dout_r;
  logic dval_r;
  wire push = i_in_valid && (lvl_r != LVL_FULL);
  // Prefetch into output register when it is empty or drained
  wire take = (lvl_r != LVL_ZERO) && (!dval_r || i_out_ready);

  // ****************************************
  // Storage and pointers
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wp_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      lvl_r <= LVL_ZERO;
      dval_r <= 1'b0;
      dout_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + PTR_ONE_L;
      if (take) begin
        rp_r <= rp_r + PTR_ONE_L;
        dout_r <= mem_r[rp_r];
      end
      lvl_r <= lvl_r + (AW+1)'(push) - (AW+1)'(take);
      if (take) dval_r <= 1'b1;
      else if (i_out_ready) dval_r <= 1'b0;
    end
  end

  assign o_in_ready = (lvl_r != LVL_FULL);
  assign o_out_valid = dval_r;
  assign o_out_data = dout_r;
endmodule

// *** bmseq_mem_model.sv ***
// ****************************************
// Memory partner, zero-wait or slow
// ****************************************
module bmseq_mem_model
  import bmseq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_lat,
  input wire logic i_rd_req,
  input wire logic [ADDR_W-1:0] i_rd_addr,
  output logic o_rd_ack,
  output logic [DATA_W-1:0] o_rd_data,
  input wire logic i_wr_req,
  input wire logic [ADDR_W-1:0] i_wr_addr,
  input wire logic [DATA_W-1:0] i_wr_data,
  output logic o_wr_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [4096];
  logic [3:0] rd_wait_r;
  logic [3:0] wr_wait_r;
  int wr_count;
  logic rd_go;
  logic wr_go;
  // Answer only once per request, after i_lat extra cycles
  assign rd_go = i_rd_req && !o_rd_ack && rd_wait_r == i_lat;
  assign wr_go = i_wr_req && !o_wr_ack && wr_wait_r == i_lat;
  // Data toggles when idle so a late sample cannot pass by luck
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rd_ack <= 1'b0;
      o_wr_ack <= 1'b0;
      rd_wait_r <= 4'h0;
      wr_wait_r <= 4'h0;
      o_rd_data <= 8'h00;
      wr_count <= 0;
    end else begin
      o_rd_ack <= rd_go;
      o_wr_ack <= wr_go;
      rd_wait_r <= (i_rd_req && !o_rd_ack && !rd_go) ? rd_wait_r + 4'h1 : 4'h0;
      wr_wait_r <= (i_wr_req && !o_wr_ack && !wr_go) ? wr_wait_r + 4'h1 : 4'h0;
      o_rd_data <= rd_go ? i_rd_addr[7:0] ^ 8'h5a : ~o_rd_data;
      if (wr_go) begin
        mem[i_wr_addr[11:0]] <= i_wr_data;
        wr_count <= wr_count + 1;
      end
    end
  end
endmodule

// *** bmseq_top_tb.sv ***
// ****************************************
// Block move sequencer bench
// ****************************************
module bmseq_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bmseq_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic [3:0] lat = 4'h0;
  bmseq_cmd_t cmd = '0;
  bmseq_res_t res;
  logic busy, done, rd_req, rd_ack, wr_req, wr_ack;
  logic [ADDR_W-1:0] rd_addr, wr_addr;
  logic [DATA_W-1:0] rd_data, wr_data;
  int failures = 0;
  int checks = 0;
  int ca, cb;
  always #10 clk = ~clk;
  bmseq_top i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_start(start),
    .i_cmd(cmd), .o_busy(busy), .o_done(done), .o_res(res),
    .o_rd_req(rd_req), .o_rd_addr(rd_addr), .i_rd_ack(rd_ack),
    .i_rd_data(rd_data), .o_wr_req(wr_req), .o_wr_addr(wr_addr),
    .o_wr_data(wr_data), .i_wr_ack(wr_ack));
  bmseq_mem_model i_mem (.i_clk(clk), .i_rst_n(rst_n), .i_lat(lat),
    .i_rd_req(rd_req), .i_rd_addr(rd_addr), .o_rd_ack(rd_ack),
    .o_rd_data(rd_data), .i_wr_req(wr_req), .i_wr_addr(wr_addr),
    .i_wr_data(wr_data), .o_wr_ack(wr_ack));
  // Verdict and end of run
  task automatic conclude();
    $display("failures %0d checks %0d", failures, checks);
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic bad(input string m);
    failures++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic chk_res(input bmseq_res_t g, input bmseq_res_t e);
    checks++;
    if (g !== e) bad("final pointers or count differ");
  endtask
  task automatic chk_bit(input logic g, input logic e);
    checks++;
    if (g !== e) bad("flag differs");
  endtask
  task automatic chk_int(input int g, input int e);
    checks++;
    if (g != e) bad("count differs");
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) bad("copied byte differs");
  endtask
  // One instruction; poke retries a start while busy, which must be lost
  task automatic run(input logic wf, input logic [15:0] cnt,
      input logic [23:0] src, input logic [23:0] dst, input logic poke,
      output int cyc);
    int n;
    int base;
    logic [23:0] a;
    n = wf ? int'(cnt) : int'(cnt[7:0]);
    base = i_mem.wr_count;
    @(posedge clk) #1;
    start = 1'b1;
    cmd = '{wf, cnt, src, dst};
    @(posedge clk) #1;
    start = 1'b0;
    cyc = 0;
    while (done !== 1'b1 && cyc < 3000) begin
      @(posedge clk) #1;
      cyc++;
      start = poke && cyc == 3;
      if (poke) cmd.count = 16'h0007;
    end
    if (cyc >= 3000) begin
      bad("no completion");
      conclude();
    end
    chk_res(res, '{16'h0000, src + 24'(n), dst + 24'(n)});
    chk_int(i_mem.wr_count - base, n);
    for (int k = 0; k < n; k++) begin
      a = dst + 24'(k);
      chk_byte(i_mem.mem[a[11:0]], 8'(src + 24'(k)) ^ 8'h5a);
    end
    @(posedge clk) #1;
    chk_bit(done | busy, 1'b0);
  endtask
  // Low byte only counts; time grows four cycles a byte
  task automatic t_byte_linear();
    run(1'b0, 16'h0102, 24'h00_0010, 24'h00_0100, 1'b0, ca);
    run(1'b0, 16'h0104, 24'h00_0010, 24'h00_0100, 1'b0, cb);
    chk_int(cb - ca, 2 * BYTE_STATES);
    chk_int(ca, BASE_STATES + 2 * BYTE_STATES);
  endtask
  // Zero count in either form skips the copy
  task automatic t_zero_skip();
    run(1'b0, 16'h0100, 24'h00_0040, 24'h00_0300, 1'b0, ca);
    chk_int(ca, BASE_STATES);
    run(1'b1, 16'h0000, 24'h00_0040, 24'h00_0300, 1'b0, ca);
    chk_int(ca, BASE_STATES);
  endtask
  // Word form uses all sixteen bits of the count
  task automatic t_word();
    run(1'b1, 16'h0100, 24'h00_0200, 24'h00_0800, 1'b0, ca);
    chk_int(ca, BASE_STATES + BYTE_STATES * 256);
  endtask
  // Slow memory stretches time but not the result
  task automatic t_slow_busy();
    lat = 4'h3;
    run(1'b0, 16'h0003, 24'h00_0020, 24'h00_0a00, 1'b1, ca);
    chk_bit(ca >= 8 + 4 * 3, 1'b1);
    lat = 4'h0;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    chk_bit(busy | done | rd_req | wr_req, 1'b0);
    t_byte_linear();
    t_zero_skip();
    t_word();
    t_slow_busy();
    conclude();
  end
endmodule
